// ---- rxs_receiver.sv ----
// receiver end: unpacks link words into video, audio and aux outputs
// assumes one i_clock; each domain is a rate given by an enable pulse
//
// Overview of operation
// - five rates, each interface in its own domain
// - audio stream rate at least 128 sample rate
// - no audio clock regeneration; system supplies it
// - reference is data rate low, data/4 high
// - data clock is reference, or four times above
// - link rate is a quarter of data rate
// - pixel rate is data over depth factor
// - native video rate is pixel over pixels_per_clock
// - link words unpack into video, audio, aux
// - stream mode bridges video onto stream rate
// - native mode sends video on native rate
// - phy end makes link and native rates
// - stream, audio, register rates run free
// - three active-low resets, each in its domain
// - device held in reset until rates settle
// - native mode drives a video reset output
// - register reset clears the whole receiver but sets video_rst
`timescale 1ns/1ps
module rxs_receiver #(
  parameter int AUD_CHANNELS = 8
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_vid_arst_n,
  input wire logic i_aud_arst_n,
  input wire logic i_native,
  input wire logic i_vid_en,
  input wire logic i_aud_en,
  rxs_if.dev link,
  output logic [rxs_pkg::PAY_W-1:0] o_vid_tdata,
  output logic o_vid_tvalid,
  input wire logic i_vid_tready,
  output logic [rxs_pkg::PAY_W-1:0] o_nat_data,
  output logic o_nat_valid,
  output logic o_video_rst,
  output logic [rxs_pkg::PAY_W-1:0] o_aud_tdata,
  output logic [$clog2(AUD_CHANNELS)-1:0] o_aud_tid,
  output logic o_aud_tvalid,
  input wire logic i_aud_tready,
  output logic [rxs_pkg::PAY_W-1:0] o_aux_data,
  output logic o_aux_valid
);
  localparam int TID_W = $clog2(AUD_CHANNELS);
  localparam logic [TID_W-1:0] TID_LAST = TID_W'(AUD_CHANNELS - 1);

  typedef struct packed {
    logic vid_s1;
    logic vid_s2;
    logic aud_s1;
    logic aud_s2;
    logic [rxs_pkg::PAY_W-1:0] vid_tdata;
    logic vid_tvalid;
    logic [rxs_pkg::PAY_W-1:0] nat_hold;
    logic nat_pend;
    logic [rxs_pkg::PAY_W-1:0] nat_data;
    logic nat_valid;
    logic video_rst;
    logic [rxs_pkg::PAY_W-1:0] aud_tdata;
    logic [TID_W-1:0] aud_tid;
    logic [TID_W-1:0] aud_next;
    logic aud_tvalid;
    logic [rxs_pkg::PAY_W-1:0] aux_data;
    logic aux_valid;
  } rxs_rx_s;

  rxs_rx_s q;
  rxs_rx_s n;

  logic link_up;
  logic vid_clr;
  logic aud_clr;
  logic take;
  logic is_vid;
  logic is_aud;
  logic is_aux;
  logic vbuf_in_valid;
  logic vbuf_in_ready;
  logic vbuf_out_valid;
  logic vbuf_pop;
  logic [rxs_pkg::PAY_W-1:0] vbuf_out_data;
  logic abuf_in_valid;
  logic abuf_in_ready;
  logic abuf_out_valid;
  logic abuf_pop;
  logic [rxs_pkg::PAY_W-1:0] abuf_out_data;

  // link domain runs only while the phy end has released it
  assign link_up = link.link_rst_n;
  assign vid_clr = !q.vid_s2;
  assign aud_clr = !q.aud_s2;
  assign take = link.link_en && link.link_valid && link_up;
  assign is_vid = (link.link_kind == rxs_pkg::RXS_KIND_VIDEO);
  assign is_aud = (link.link_kind == rxs_pkg::RXS_KIND_AUDIO);
  assign is_aux = (link.link_kind == rxs_pkg::RXS_KIND_AUX);

  // unpack link words by kind
  assign vbuf_in_valid = take && is_vid && !i_native;
  assign abuf_in_valid = take && is_aud;

  // back-pressure to the phy end follows the target path
  always_comb begin
    link.link_ready = link_up;
    if (is_vid && !i_native) begin
      link.link_ready = link_up && vbuf_in_ready;
    end else if (is_aud) begin
      link.link_ready = link_up && abuf_in_ready;
    end
  end

  // stream stage loads from the buffer on stream video ticks
  assign vbuf_pop = i_vid_en && !i_native && (!q.vid_tvalid || i_vid_tready);
  assign abuf_pop = i_aud_en && (!q.aud_tvalid || i_aud_tready);

  // video crosses from link rate to stream rate through a buffer
  rxs_pair_buf #(
    .W(rxs_pkg::PAY_W)
  ) u_vbuf (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clr(vid_clr),
    .i_in_valid(vbuf_in_valid),
    .o_in_ready(vbuf_in_ready),
    .i_in_data(link.link_data),
    .o_out_valid(vbuf_out_valid),
    .i_out_ready(vbuf_pop),
    .o_out_data(vbuf_out_data)
  );

  // audio crosses from link rate to audio stream rate
  rxs_pair_buf #(
    .W(rxs_pkg::PAY_W)
  ) u_abuf (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clr(aud_clr),
    .i_in_valid(abuf_in_valid),
    .o_in_ready(abuf_in_ready),
    .i_in_data(link.link_data),
    .o_out_valid(abuf_out_valid),
    .i_out_ready(abuf_pop),
    .o_out_data(abuf_out_data)
  );

  always_comb begin
    n = q;
    // domain resets pass two flops before use
    n.vid_s1 = i_vid_arst_n;
    n.vid_s2 = q.vid_s1;
    n.aud_s1 = i_aud_arst_n;
    n.aud_s2 = q.aud_s1;

    // video reset for native downstream follows the link reset
    n.video_rst = !link_up;

    // stream video output
    if (i_vid_en && q.vid_tvalid && i_vid_tready) begin
      n.vid_tvalid = 1'b0;
    end
    if (vbuf_pop && vbuf_out_valid) begin
      n.vid_tvalid = 1'b1;
      n.vid_tdata = vbuf_out_data;
    end
    if (vid_clr) begin
      n.vid_tvalid = 1'b0;
      n.vid_tdata = '0;
    end

    // native video straight from the link, no bridge
    n.nat_valid = 1'b0;
    if (link.video_en && q.nat_pend) begin
      n.nat_valid = 1'b1;
      n.nat_data = q.nat_hold;
      n.nat_pend = 1'b0;
    end
    // a new word wins over the clear of the pending flag
    if (take && is_vid && i_native) begin
      n.nat_hold = link.link_data;
      n.nat_pend = 1'b1;
    end
    if (!link_up) begin
      n.nat_pend = 1'b0;
      n.nat_valid = 1'b0;
    end

    // audio stream with channel number in sequence
    if (i_aud_en && q.aud_tvalid && i_aud_tready) begin
      n.aud_tvalid = 1'b0;
    end
    if (abuf_pop && abuf_out_valid) begin
      n.aud_tvalid = 1'b1;
      n.aud_tdata = abuf_out_data;
      n.aud_tid = q.aud_next;
      n.aud_next = (q.aud_next == TID_LAST) ? '0 : q.aud_next + TID_W'(1);
    end
    if (aud_clr) begin
      n.aud_tvalid = 1'b0;
      n.aud_tdata = '0;
      n.aud_tid = '0;
      n.aud_next = '0;
    end

    // aux words pulse out in the link domain
    n.aux_valid = take && is_aux;
    if (take && is_aux) begin
      n.aux_data = link.link_data;
    end
  end

  // register reset clears everything, link path included, except video_rst, which loads VIDEO_RST_INIT
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
      q.video_rst <= rxs_pkg::VIDEO_RST_INIT;
    end else begin
      q <= n;
    end
  end

  assign o_vid_tdata = q.vid_tdata;
  assign o_vid_tvalid = q.vid_tvalid;
  assign o_nat_data = q.nat_data;
  assign o_nat_valid = q.nat_valid;
  assign o_video_rst = q.video_rst;
  assign o_aud_tdata = q.aud_tdata;
  assign o_aud_tid = q.aud_tid;
  assign o_aud_tvalid = q.aud_tvalid;
  assign o_aux_data = q.aux_data;
  assign o_aux_valid = q.aux_valid;
endmodule

// ---- rxs_pkg.sv ----
// shared constants and types for the receiver clock and reset structure
// assumes both ends and the pair buffer use the same link word layout
package rxs_pkg;

  // link word: kind field above a payload field
  localparam int PAY_W = 24;
  localparam int KIND_W = 2;
  localparam int LINK_W = KIND_W + PAY_W;

  typedef enum logic [1:0] {
    RXS_KIND_VIDEO = 2'h0,
    RXS_KIND_AUDIO = 2'h1,
    RXS_KIND_AUX = 2'h2,
    RXS_KIND_IDLE = 2'h3
  } rxs_kind_e;

  typedef enum logic [1:0] {
    RXS_BPC_8 = 2'h0,
    RXS_BPC_10 = 2'h1,
    RXS_BPC_12 = 2'h2,
    RXS_BPC_16 = 2'h3
  } rxs_bpc_e;

  // data-rate ticks per link tick, and per reference tick above 3.4 Gb/s
  localparam logic [1:0] LINK_DATA_LAST = 2'h3;
  localparam logic [1:0] REF_HIGH_LAST = 2'h3;
  // pixels per native video tick
  localparam logic [2:0] PPC_DUAL = 3'h2;
  localparam logic [2:0] PPC_QUAD = 3'h4;
  // pixel rate accumulator: add step per data tick, wrap at threshold
  localparam logic [3:0] PIX_STEP = 4'h4;
  localparam logic [3:0] PIX_THR_8 = 4'h4;
  localparam logic [3:0] PIX_THR_10 = 4'h5;
  localparam logic [3:0] PIX_THR_12 = 4'h6;
  localparam logic [3:0] PIX_THR_16 = 4'h8;
  // least ratio of audio stream rate to audio sample rate
  localparam int AUD_RATIO_MIN = 128;
  // default settle time before the link is released from reset
  localparam int LOCK_CYCLES = 16;
  // reset value of the video reset output of the receiver
  localparam logic VIDEO_RST_INIT = 1'b1;

  function automatic logic [3:0] rxs_pix_thr(input rxs_bpc_e bpc);
    logic [3:0] thr;
    thr = PIX_THR_8;
    unique case (bpc)
      RXS_BPC_8: thr = PIX_THR_8;
      RXS_BPC_10: thr = PIX_THR_10;
      RXS_BPC_12: thr = PIX_THR_12;
      RXS_BPC_16: thr = PIX_THR_16;
    endcase
    return thr;
  endfunction

endpackage

// ---- rxs_if.sv ----
// link between the phy controller end and the receiver end
// assumes both ends run on the same i_clock; rates are enable pulses
`timescale 1ns/1ps
interface rxs_if;
  logic link_en;
  logic video_en;
  logic link_rst_n;
  logic link_valid;
  logic [rxs_pkg::KIND_W-1:0] link_kind;
  logic [rxs_pkg::PAY_W-1:0] link_data;
  logic link_ready;

  modport dev (
    input link_en,
    input video_en,
    input link_rst_n,
    input link_valid,
    input link_kind,
    input link_data,
    output link_ready
  );

  modport phy (
    output link_en,
    output video_en,
    output link_rst_n,
    output link_valid,
    output link_kind,
    output link_data,
    input link_ready
  );
endinterface

// ---- rxs_pair_buf.sv ----
// two-entry buffer with valid and ready on both sides
// assumes i_clr is a synchronous clear from the owning domain
`timescale 1ns/1ps
module rxs_pair_buf #(
  parameter int W = 24
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clr,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0] cnt;
  } rxs_buf_s;

  rxs_buf_s q;
  rxs_buf_s n;
  logic push;
  logic pop;

  assign o_in_ready = (q.cnt != 2'h2);
  assign o_out_valid = (q.cnt != 2'h0);
  assign o_out_data = q.d0;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    n = q;
    if (pop) begin
      n.d0 = q.d1;
    end
    if (push) begin
      if ((q.cnt == 2'h0) || (pop && (q.cnt == 2'h1))) begin
        n.d0 = i_in_data;
      end else begin
        n.d1 = i_in_data;
      end
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    if (i_clr) begin
      n = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- rxs_phy_end.sv ----
// phy controller end: makes link and native video rates, drives link words
// assumes the data rate is i_clock divided by DATA_DIV
`timescale 1ns/1ps
module rxs_phy_end #(
  parameter int DATA_DIV = 1,
  parameter int LOCK_CNT = rxs_pkg::LOCK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_high_rate,
  input wire logic [1:0] i_bpc,
  input wire logic i_ppc_quad,
  input wire logic i_word_valid,
  output logic o_word_ready,
  input wire logic [rxs_pkg::KIND_W-1:0] i_word_kind,
  input wire logic [rxs_pkg::PAY_W-1:0] i_word_data,
  output logic o_ref_en,
  output logic o_locked,
  rxs_if.phy link
);
  typedef struct packed {
    logic [15:0] div_cnt;
    logic [1:0] link_cnt;
    logic [1:0] ref_cnt;
    logic [3:0] pix_acc;
    logic [2:0] pix_cnt;
    logic [15:0] lock_cnt;
    logic locked;
    logic link_en;
    logic video_en;
    logic ref_en;
    logic hold_v;
    logic [rxs_pkg::KIND_W-1:0] hold_k;
    logic [rxs_pkg::PAY_W-1:0] hold_d;
  } rxs_phy_s;

  rxs_phy_s q;
  rxs_phy_s n;
  logic data_tick;
  logic [3:0] thr;
  logic [3:0] sum;
  logic [2:0] ppc_last;

  assign data_tick = (q.div_cnt == 16'(DATA_DIV - 1));
  assign thr = rxs_pkg::rxs_pix_thr(rxs_pkg::rxs_bpc_e'(i_bpc));
  assign sum = q.pix_acc + rxs_pkg::PIX_STEP;
  assign ppc_last = (i_ppc_quad ? rxs_pkg::PPC_QUAD : rxs_pkg::PPC_DUAL) - 3'h1;

  assign o_word_ready = !q.hold_v;
  assign o_ref_en = q.ref_en;
  assign o_locked = q.locked;
  assign link.link_en = q.link_en;
  assign link.video_en = q.video_en;
  assign link.link_rst_n = q.locked;
  assign link.link_valid = q.hold_v;
  assign link.link_kind = q.hold_k;
  assign link.link_data = q.hold_d;

  always_comb begin
    n = q;
    n.link_en = 1'b0;
    n.video_en = 1'b0;
    n.ref_en = 1'b0;
    // free-running base divider
    n.div_cnt = data_tick ? 16'h0000 : q.div_cnt + 16'h0001;
    // hold the link in reset until the rates have settled
    if (q.lock_cnt != 16'(LOCK_CNT)) begin
      n.lock_cnt = q.lock_cnt + 16'h0001;
    end else begin
      n.locked = 1'b1;
    end
    if (data_tick) begin
      // reference rate equals data rate below 3.4 Gb/s, quarter above
      n.ref_cnt = (q.ref_cnt == rxs_pkg::REF_HIGH_LAST) ? 2'h0 : q.ref_cnt + 2'h1;
      n.ref_en = !i_high_rate || (q.ref_cnt == rxs_pkg::REF_HIGH_LAST);
      // link rate is a quarter of the data rate
      n.link_cnt = q.link_cnt + 2'h1;
      n.link_en = (q.link_cnt == rxs_pkg::LINK_DATA_LAST);
      // pixel rate from data rate by colour depth
      if (sum >= thr) begin
        n.pix_acc = sum - thr;
        // native video rate is pixel rate over pixels per clock
        n.pix_cnt = (q.pix_cnt == ppc_last) ? 3'h0 : q.pix_cnt + 3'h1;
        n.video_en = (q.pix_cnt == ppc_last);
      end else begin
        n.pix_acc = sum;
      end
    end
    // word leaves when the receiver takes it on a link tick
    if (q.link_en && q.hold_v && link.link_ready) begin
      n.hold_v = 1'b0;
    end
    if (i_word_valid && !q.hold_v) begin
      n.hold_v = 1'b1;
      n.hold_k = i_word_kind;
      n.hold_d = i_word_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- dummy_unused_guard.sv ----
// holds no logic of the block
// assumes nothing; both ends and the pair buffer live in their own files

// ---- rxs_link_properties.sv ----
// checker for the link between the phy controller end and the receiver end
// assumes one clock; instantiated by the testbench beside the link interface
`timescale 1ns/1ps
module rxs_link_properties #(
  parameter int LOCK_CNT = rxs_pkg::LOCK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic link_en,
  input wire logic video_en,
  input wire logic link_rst_n,
  input wire logic link_valid,
  input wire logic [rxs_pkg::KIND_W-1:0] link_kind,
  input wire logic [rxs_pkg::PAY_W-1:0] link_data,
  input wire logic link_ready
);
  logic [7:0] since_q;
  logic [7:0] since_d;

  // edges since reset release, saturating
  always_comb begin
    since_d = (since_q == 8'hff) ? since_q : since_q + 8'h01;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      since_q <= 8'h00;
    end else begin
      since_q <= since_d;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence s_held;
    link_valid && !(link_en && link_ready && link_rst_n);
  endsequence

  sequence s_link_gap;
    !link_en [*3] ##1 link_en;
  endsequence

  chk_word_data_hold: assert property (s_held |=> link_valid && $stable(link_data))
    else $error("link word dropped or changed before taken");
  chk_word_kind_hold: assert property (s_held |=> $stable(link_kind))
    else $error("link kind changed before taken");
  chk_link_rate_quarter: assert property (link_en |=> s_link_gap)
    else $error("link tick not every fourth data tick");
  chk_video_tick_pulse: assert property (video_en |=> !video_en)
    else $error("video tick faster than half the data rate");
  chk_ready_in_reset: assert property (!link_rst_n |-> !link_ready)
    else $error("receiver ready while link held in reset");
  chk_lock_wait: assert property ((since_q < LOCK_CNT) |-> !link_rst_n)
    else $error("link released before settle time");
  chk_lock_bound: assert property ((since_q == LOCK_CNT + 3) |-> link_rst_n)
    else $error("link not released after settle time");
  chk_lock_stays: assert property (link_rst_n |=> link_rst_n)
    else $error("link reset returned without a reset");
endmodule

// ---- av_receiver_clock_reset_tb.sv ----
// testbench: phy end and receiver joined by the link interface
// assumes one 10 MHz clock; stream and audio rates are tick enables
`timescale 1ns/1ps
module av_receiver_clock_reset_tb;
  localparam int LOCK_N = 2;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_high_rate = 1'b0;
  logic [1:0] i_bpc = 2'h0;
  logic i_ppc_quad = 1'b0;
  logic i_word_valid = 1'b0;
  logic [rxs_pkg::KIND_W-1:0] i_word_kind = 2'h0;
  logic [rxs_pkg::PAY_W-1:0] i_word_data = 24'h0;
  logic i_vid_arst_n = 1'b0;
  logic i_aud_arst_n = 1'b0;
  logic i_native = 1'b0;
  logic i_vid_en = 1'b0;
  logic i_aud_en = 1'b0;
  logic i_vid_tready = 1'b0;
  logic i_aud_tready = 1'b1;
  logic o_word_ready, o_ref_en, o_locked, o_vid_tvalid, o_nat_valid, o_video_rst;
  logic o_aud_tvalid, o_aux_valid;
  logic [rxs_pkg::PAY_W-1:0] o_vid_tdata, o_nat_data, o_aud_tdata, o_aux_data;
  logic [2:0] o_aud_tid;
  logic refused = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int div_q = 0;
  int n_ref = 0;
  int n_link = 0;
  int n_vid = 0;
  int thr[4] = '{4, 5, 6, 8};

  rxs_if lnk();
  rxs_phy_end #(.LOCK_CNT(LOCK_N)) u_rxs_phy_end (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_high_rate(i_high_rate), .i_bpc(i_bpc), .i_ppc_quad(i_ppc_quad),
    .i_word_valid(i_word_valid), .o_word_ready(o_word_ready), .i_word_kind(i_word_kind),
    .i_word_data(i_word_data), .o_ref_en(o_ref_en), .o_locked(o_locked), .link(lnk));
  rxs_receiver #(.AUD_CHANNELS(8)) u_rxs_receiver (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_vid_arst_n(i_vid_arst_n), .i_aud_arst_n(i_aud_arst_n), .i_native(i_native),
    .i_vid_en(i_vid_en), .i_aud_en(i_aud_en), .link(lnk), .o_vid_tdata(o_vid_tdata),
    .o_vid_tvalid(o_vid_tvalid), .i_vid_tready(i_vid_tready), .o_nat_data(o_nat_data),
    .o_nat_valid(o_nat_valid), .o_video_rst(o_video_rst), .o_aud_tdata(o_aud_tdata),
    .o_aud_tid(o_aud_tid), .o_aud_tvalid(o_aud_tvalid), .i_aud_tready(i_aud_tready),
    .o_aux_data(o_aux_data), .o_aux_valid(o_aux_valid));
  rxs_link_properties #(.LOCK_CNT(LOCK_N)) u_rxs_link_properties (.i_clock(i_clock),
    .i_arst_n(i_arst_n), .link_en(lnk.link_en), .video_en(lnk.video_en),
    .link_rst_n(lnk.link_rst_n), .link_valid(lnk.link_valid), .link_kind(lnk.link_kind),
    .link_data(lnk.link_data), .link_ready(lnk.link_ready));

  always #50 i_clock = ~i_clock;

  // free-running stream ticks and rate counters
  always @(posedge i_clock) begin
    div_q <= div_q + 1;
    i_vid_en <= (div_q % 3 == 0);
    i_aud_en <= (div_q % 5 == 0);
    n_ref <= n_ref + int'(o_ref_en === 1'b1);
    n_link <= n_link + int'(lnk.link_en === 1'b1);
    n_vid <= n_vid + int'(lnk.video_en === 1'b1);
    if (lnk.link_valid && lnk.link_en && lnk.link_rst_n && lnk.link_ready === 1'b0) begin
      refused <= 1'b1;
    end
  end

  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp_word(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_flag(input string nm, input logic e, input logic g);
    cmp_word(nm, {23'h0, e}, {23'h0, g});
  endtask

  task automatic cmp_cnt(input string nm, input int e, input int g);
    cmp_count++;
    if (g < e - 1 || g > e + 1) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // word held until the phy end takes it; valid left high
  task automatic send_word(input logic [1:0] k, input logic [23:0] d);
    int n;
    n = 0;
    i_word_valid <= 1'b1;
    i_word_kind <= k;
    i_word_data <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_word_ready !== 1'b1 && n < 400);
    if (o_word_ready !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED word_ready expected 1 seen %b", o_word_ready);
    end
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: return i_vid_en & o_vid_tvalid & i_vid_tready;
      1: return i_aud_en & o_aud_tvalid & i_aud_tready;
      2: return o_nat_valid;
      default: return o_aux_valid;
    endcase
  endfunction

  // waits for one output transfer and compares its payload
  task automatic get_out(input int sel, input logic [23:0] e, input logic [2:0] tid);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (hit(sel) !== 1'b1 && n < 400);
    if (hit(sel) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED transfer %0d expected 1 seen %b", sel, hit(sel));
    end
    case (sel)
      0: cmp_word("vid_tdata", e, o_vid_tdata);
      1: cmp_word("aud_tdata", e, o_aud_tdata);
      2: cmp_word("nat_data", e, o_nat_data);
      default: cmp_word("aux_data", e, o_aux_data);
    endcase
    if (sel == 1) begin
      cmp_word("aud_tid", {21'h0, tid}, {21'h0, o_aud_tid});
    end
  endtask

  initial begin
    #2000000;
    error_cnt++;
    close_out();
  end

  initial begin
    int n0;
    int r0;
    int l0;
    repeat (16) @(posedge i_clock);
    cmp_flag("video_rst", 1'b1, o_video_rst);
    cmp_flag("link_ready", 1'b0, lnk.link_ready);
    i_arst_n <= 1'b1;
    i_vid_arst_n <= 1'b1;
    i_aud_arst_n <= 1'b1;
    repeat (LOCK_N + 8) @(posedge i_clock);
    cmp_flag("locked", 1'b1, o_locked);
    cmp_flag("video_rst", 1'b0, o_video_rst);
    // stalled stream sink: buffer fills, link refuses, nothing lost
    fork
      begin
        for (int i = 0; i < 5; i++) send_word(2'h0, 24'ha00000 + 24'(i));
        i_word_valid <= 1'b0;
      end
      begin
        repeat (80) @(posedge i_clock);
        cmp_flag("refused", 1'b1, refused);
        i_vid_tready <= 1'b1;
        for (int i = 0; i < 5; i++) get_out(0, 24'ha00000 + 24'(i), 3'h0);
      end
    join
    // audio words carry channel ids in order
    fork
      begin
        for (int i = 0; i < 3; i++) send_word(2'h1, 24'hb00000 + 24'(i));
        i_word_valid <= 1'b0;
      end
      for (int i = 0; i < 3; i++) get_out(1, 24'hb00000 + 24'(i), 3'(i));
    join
    send_word(2'h2, 24'hc3a5e1);
    i_word_valid <= 1'b0;
    get_out(3, 24'hc3a5e1, 3'h0);
    i_native <= 1'b1;
    send_word(2'h0, 24'h3c5a01);
    i_word_valid <= 1'b0;
    get_out(2, 24'h3c5a01, 3'h0);
    cmp_flag("vid_tvalid", 1'b0, o_vid_tvalid);
    i_native <= 1'b0;
    // audio reset clears a waiting sample
    i_aud_tready <= 1'b0;
    send_word(2'h1, 24'hd00001);
    i_word_valid <= 1'b0;
    repeat (30) @(posedge i_clock);
    cmp_flag("aud_tvalid", 1'b1, o_aud_tvalid);
    i_aud_arst_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_aud_arst_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    cmp_flag("aud_tvalid", 1'b0, o_aud_tvalid);
    i_aud_tready <= 1'b1;
    // rate relations over every depth and pixels per clock
    for (int b = 0; b < 4; b++) begin
      for (int q = 0; q < 2; q++) begin
        i_bpc <= 2'(b);
        i_ppc_quad <= q[0];
        i_high_rate <= q[0];
        repeat (20) @(posedge i_clock);
        n0 = n_vid;
        r0 = n_ref;
        l0 = n_link;
        repeat (480) @(posedge i_clock);
        cmp_cnt("video_ticks", 1920 / (thr[b] * (q ? 4 : 2)), n_vid - n0);
        cmp_cnt("ref_ticks", q ? 120 : 480, n_ref - r0);
        cmp_cnt("link_ticks", 120, n_link - l0);
      end
    end
    // register reset in mid-run raises video_rst and drops link_ready
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    cmp_flag("video_rst", 1'b1, o_video_rst);
    cmp_flag("link_ready", 1'b0, lnk.link_ready);
    i_arst_n <= 1'b1;
    repeat (LOCK_N + 8) @(posedge i_clock);
    cmp_flag("video_rst", 1'b0, o_video_rst);
    close_out();
  end
endmodule
